// [sflm_pkg.sv]
package sflm_pkg;

   // Fault bit positions in the status vector
   localparam int FAULT_COUNT = 9;
   localparam int F_LINK = 0;
   localparam int F_SECFILE = 1;
   localparam int F_POLICY = 2;
   localparam int F_SENSOR = 3;
   localparam int F_OVERTEMP = 4;
   localparam int F_JUNCTION = 5;
   localparam int F_LONGSTART = 6;
   localparam int F_UNDERLOAD = 7;
   localparam int F_MAINS = 8;

   // Clearing policy per fault bit
   localparam logic [8:0] AUTO_CLEAR_MASK = 9'h199;
   localparam logic [8:0] SELF_CLEAR_MASK = 9'h006;
   localparam logic [8:0] FAULTS_RESET = 9'h000;

   // Timing
   localparam int CLK_KHZ = 125000;
   localparam int LINK_SILENCE_MS = 2000;
   localparam int LINK_SILENCE_CYCLES = LINK_SILENCE_MS * CLK_KHZ;
   localparam int MS_TICK_CYCLES = CLK_KHZ;
   localparam int START_TIME_W = 16;
   localparam int LINK_CNT_W = 32;
   localparam int MS_CNT_W = 17;

   // Active fault report codes
   typedef enum logic [3:0] {
      CODE_NONE = 4'h0,
      CODE_LINK = 4'h1,
      CODE_SECFILE = 4'h2,
      CODE_POLICY = 4'h3,
      CODE_SENSOR = 4'h4,
      CODE_OVERTEMP = 4'h5,
      CODE_JUNCTION = 4'h6,
      CODE_LONGSTART = 4'h7,
      CODE_UNDERLOAD = 4'h8,
      CODE_MAINS = 4'h9
   } sflm_code_t;

   localparam sflm_code_t CODE_RESET = CODE_NONE;

   // Active operator interface
   typedef enum logic {
      HMI_REMOTE = 1'b0,
      HMI_EMBEDDED = 1'b1
   } sflm_hmi_t;

   localparam sflm_hmi_t HMI_RESET = HMI_REMOTE;

   // Raw fault causes from the monitors
   typedef struct packed {
      logic mains_bad;
      logic mains_dip;
      logic underload;
      logic junction_hot;
      logic overtemp;
      logic sensor_short;
      logic sensor_open;
      logic policy_xfer_fail;
      logic policy_invalid;
      logic sec_file_bad;
      logic sec_file_absent;
   } sflm_cause_t;

endpackage

// [sflm_timeout.sv]
`timescale 1ns/1ps
module sflm_timeout #(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Control
   input wire logic run_in,
   input wire logic tick_in,
   input wire logic [W-1:0] limit_in,
   // Status
   output logic [W-1:0] count_out,
   output logic expired_out
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic exp_reg;
   logic exp_next;

   // Expiry after limit plus one ticks, held while running
   always_comb begin
      cnt_next = cnt_reg;
      exp_next = exp_reg;
      if (!run_in) begin
         cnt_next = '0;
         exp_next = 1'b0;
      end else if (tick_in && !exp_reg) begin
         if (cnt_reg == limit_in) begin
            exp_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= '0;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
      end
   end

   assign count_out = cnt_reg;
   assign expired_out = exp_reg;

endmodule

// [sflm_fault_manager.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Link fault after over 2 s terminal silence
// RULE2: Link fault forces embedded display terminal
// RULE3: Bad or missing security file raises fault
// RULE4: Failed policy transfer or invalid config raises fault
// RULE5: Security faults clear themselves when cause ends
// RULE6: Sensor open or short raises sensor fault
// RULE7: Sensor overtemperature raises overtemp fault
// RULE8: Thyristor junction overheating raises fault
// RULE9: Start timeout before start done raises fault
// RULE10: Bad mains or voltage dip raises fault
// RULE11: Five faults clear by auto or manual
// RULE12: Junction and long start clear manually only
// RULE13: Faults latched, readable, active one reported
module sflm_fault_manager #(
   parameter int LINK_SILENCE_CYCLES = sflm_pkg::LINK_SILENCE_CYCLES,
   parameter int MS_TICK_CYCLES = sflm_pkg::MS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Monitor causes
   input wire sflm_pkg::sflm_cause_t cause_in,
   // Display terminal link
   input wire logic cmd_from_terminal_in,
   input wire logic link_traffic_in,
   input wire logic remote_hmi_request_in,
   // Start supervision
   input wire logic start_active_in,
   input wire logic start_done_in,
   input wire logic [sflm_pkg::START_TIME_W-1:0] max_start_time_in,
   // Clearing
   input wire logic automatic_clear_in,
   input wire logic manual_clear_in,
   // Status
   output logic [sflm_pkg::FAULT_COUNT-1:0] fault_status_out,
   output sflm_pkg::sflm_code_t active_fault_out,
   output logic any_fault_out,
   output sflm_pkg::sflm_hmi_t active_hmi_out
);

   localparam int N = sflm_pkg::FAULT_COUNT;
   localparam int LW = sflm_pkg::LINK_CNT_W;
   localparam int MW = sflm_pkg::MS_CNT_W;
   localparam int SW = sflm_pkg::START_TIME_W;

   logic [N-1:0] fault_reg;
   logic [N-1:0] fault_next;
   logic [N-1:0] cause;
   logic [N-1:0] clear_ok;
   sflm_pkg::sflm_code_t code_reg;
   sflm_pkg::sflm_code_t code_next;
   logic any_reg;
   logic any_next;
   sflm_pkg::sflm_hmi_t hmi_reg;
   sflm_pkg::sflm_hmi_t hmi_next;
   logic [MW-1:0] ms_cnt_reg;
   logic [MW-1:0] ms_cnt_next;
   logic ms_tick;
   logic link_run;
   logic link_expired;
   logic start_run;
   logic start_expired;

   // Terminal silence watchdog, only while commands come from the terminal
   assign link_run = cmd_from_terminal_in && !link_traffic_in; // RULE1

   sflm_timeout #(
      .W(LW)
   ) u_link_timeout (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .run_in(link_run),
      .tick_in(1'b1),
      .limit_in(LW'(LINK_SILENCE_CYCLES)),
      .count_out(),
      .expired_out(link_expired)
   );

   // Millisecond tick for the start timer
   always_comb begin
      ms_tick = (ms_cnt_reg == MW'(MS_TICK_CYCLES - 1));
      ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + MW'(1);
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ms_cnt_reg <= '0;
      end else begin
         ms_cnt_reg <= ms_cnt_next;
      end
   end

   // Start timer runs from start until end-of-start conditions are met
   assign start_run = start_active_in && !start_done_in; // RULE9

   sflm_timeout #(
      .W(SW)
   ) u_start_timeout (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .run_in(start_run),
      .tick_in(ms_tick),
      .limit_in(max_start_time_in),
      .count_out(),
      .expired_out(start_expired)
   );

   // Cause vector
   always_comb begin
      cause = '0;
      cause[sflm_pkg::F_LINK] = link_expired && link_run; // RULE1
      cause[sflm_pkg::F_SECFILE] = cause_in.sec_file_bad || cause_in.sec_file_absent; // RULE3
      cause[sflm_pkg::F_POLICY] = cause_in.policy_xfer_fail || cause_in.policy_invalid; // RULE4
      cause[sflm_pkg::F_SENSOR] = cause_in.sensor_open || cause_in.sensor_short; // RULE6
      cause[sflm_pkg::F_OVERTEMP] = cause_in.overtemp; // RULE7
      cause[sflm_pkg::F_JUNCTION] = cause_in.junction_hot; // RULE8
      cause[sflm_pkg::F_LONGSTART] = start_expired; // RULE9
      cause[sflm_pkg::F_UNDERLOAD] = cause_in.underload;
      cause[sflm_pkg::F_MAINS] = cause_in.mains_bad || cause_in.mains_dip; // RULE10
   end

   // Per-fault latch; a present cause always wins over a clear
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_fault
         assign clear_ok[gi] = !cause[gi] &&
            (manual_clear_in || (automatic_clear_in && sflm_pkg::AUTO_CLEAR_MASK[gi])); // RULE11 RULE12
         assign fault_next[gi] = sflm_pkg::SELF_CLEAR_MASK[gi] ? cause[gi] : // RULE5
            (cause[gi] || (fault_reg[gi] && !clear_ok[gi])); // RULE13
      end
   endgenerate

   // Report the lowest-numbered active fault
   always_comb begin
      code_next = sflm_pkg::CODE_NONE;
      any_next = |fault_next;
      for (int i = N - 1; i >= 0; i--) begin
         if (fault_next[i]) begin
            code_next = sflm_pkg::sflm_code_t'(4'(i + 1)); // RULE13
         end
      end
   end

   // Operator interface selection
   always_comb begin
      hmi_next = hmi_reg;
      unique case (hmi_reg)
         sflm_pkg::HMI_REMOTE: begin
            if (fault_next[sflm_pkg::F_LINK]) begin
               hmi_next = sflm_pkg::HMI_EMBEDDED; // RULE2
            end
         end
         sflm_pkg::HMI_EMBEDDED: begin
            if (remote_hmi_request_in && !fault_next[sflm_pkg::F_LINK]) begin
               hmi_next = sflm_pkg::HMI_REMOTE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fault_reg <= sflm_pkg::FAULTS_RESET;
         code_reg <= sflm_pkg::CODE_RESET;
         any_reg <= 1'b0;
         hmi_reg <= sflm_pkg::HMI_RESET;
      end else begin
         fault_reg <= fault_next;
         code_reg <= code_next;
         any_reg <= any_next;
         hmi_reg <= hmi_next;
      end
   end

   assign fault_status_out = fault_reg;
   assign active_fault_out = code_reg;
   assign any_fault_out = any_reg;
   assign active_hmi_out = hmi_reg;

   // Helper: cycles of continuous terminal silence
   logic [LW-1:0] silence_cnt_reg;
   logic [LW-1:0] silence_cnt_next;

   always_comb begin
      silence_cnt_next = '0;
      if (link_run && (silence_cnt_reg != '1)) begin
         silence_cnt_next = silence_cnt_reg + LW'(1);
      end else if (link_run) begin
         silence_cnt_next = silence_cnt_reg;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         silence_cnt_reg <= '0;
      end else begin
         silence_cnt_reg <= silence_cnt_next;
      end
   end

   property p_link_after_silence;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(link_expired) |-> (silence_cnt_reg == LW'(LINK_SILENCE_CYCLES + 1));
   endproperty
   a_link_after_silence: assert property (p_link_after_silence) // RULE1
      else $error("Link fault timing wrong");

   property p_link_needs_terminal;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(fault_status_out[sflm_pkg::F_LINK]) |-> $past(cmd_from_terminal_in);
   endproperty
   a_link_needs_terminal: assert property (p_link_needs_terminal) // RULE1
      else $error("Link fault without terminal command source");

   property p_hmi_fallback;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      fault_status_out[sflm_pkg::F_LINK] |-> (active_hmi_out == sflm_pkg::HMI_EMBEDDED);
   endproperty
   a_hmi_fallback: assert property (p_hmi_fallback) // RULE2
      else $error("Active interface not embedded during link fault");

   property p_secfile_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (cause_in.sec_file_bad || cause_in.sec_file_absent)
         |=> fault_status_out[sflm_pkg::F_SECFILE];
   endproperty
   a_secfile_set: assert property (p_secfile_set) // RULE3
      else $error("Security file fault not raised");

   property p_policy_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (cause_in.policy_xfer_fail || cause_in.policy_invalid)
         |=> fault_status_out[sflm_pkg::F_POLICY];
   endproperty
   a_policy_set: assert property (p_policy_set) // RULE4
      else $error("Policy update fault not raised");

   property p_self_clear;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !(cause_in.sec_file_bad || cause_in.sec_file_absent)
         ##0 !(cause_in.policy_xfer_fail || cause_in.policy_invalid)
         |=> !fault_status_out[sflm_pkg::F_SECFILE] && !fault_status_out[sflm_pkg::F_POLICY];
   endproperty
   a_self_clear: assert property (p_self_clear) // RULE5
      else $error("Security fault did not clear by itself");

   property p_sensor_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (cause_in.sensor_open || cause_in.sensor_short) |=> fault_status_out[sflm_pkg::F_SENSOR];
   endproperty
   a_sensor_set: assert property (p_sensor_set) // RULE6
      else $error("Sensor fault not raised");

   property p_overtemp_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      cause_in.overtemp |=> fault_status_out[sflm_pkg::F_OVERTEMP];
   endproperty
   a_overtemp_set: assert property (p_overtemp_set) // RULE7
      else $error("Overtemp fault not raised");

   property p_junction_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      cause_in.junction_hot |=> fault_status_out[sflm_pkg::F_JUNCTION];
   endproperty
   a_junction_set: assert property (p_junction_set) // RULE8
      else $error("Junction fault not raised");

   property p_longstart_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(start_expired) |-> $past(start_run) ##1 fault_status_out[sflm_pkg::F_LONGSTART];
   endproperty
   a_longstart_set: assert property (p_longstart_set) // RULE9
      else $error("Long start fault not raised");

   property p_mains_set;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (cause_in.mains_bad || cause_in.mains_dip) |=> fault_status_out[sflm_pkg::F_MAINS];
   endproperty
   a_mains_set: assert property (p_mains_set) // RULE10
      else $error("Mains undervolt fault not raised");

   property p_auto_clear;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      fault_status_out[sflm_pkg::F_UNDERLOAD] && automatic_clear_in && !cause_in.underload
         |=> !fault_status_out[sflm_pkg::F_UNDERLOAD];
   endproperty
   a_auto_clear: assert property (p_auto_clear) // RULE11
      else $error("Underload fault not auto cleared");

   property p_manual_only;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      fault_status_out[sflm_pkg::F_JUNCTION] && !manual_clear_in
         |=> fault_status_out[sflm_pkg::F_JUNCTION];
   endproperty
   a_manual_only: assert property (p_manual_only) // RULE12
      else $error("Junction fault cleared without manual clear");

   property p_report;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (any_fault_out == (fault_status_out != '0))
         && ((active_fault_out == sflm_pkg::CODE_NONE) == (fault_status_out == '0));
   endproperty
   a_report: assert property (p_report) // RULE13
      else $error("Fault report inconsistent with status");

endmodule

// [sflm_partner.sv]
`timescale 1ns/1ps
module sflm_partner #(
   parameter int GAP = 4
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Terminal behaviour
   input wire logic alive_in,
   input wire logic cmd_in,
   // Link to block
   output logic cmd_from_terminal_out,
   output logic link_traffic_out
);
   logic [3:0] gap_reg;
   logic [3:0] gap_next;

   // Connected terminal sends one frame every GAP cycles
   always_comb begin
      gap_next = (gap_reg == 4'(GAP - 1)) ? 4'h0 : gap_reg + 4'h1;
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gap_reg <= 4'h0;
      end else begin
         gap_reg <= gap_next;
      end
   end

   assign link_traffic_out = alive_in && (gap_reg == 4'h0);
   assign cmd_from_terminal_out = cmd_in;
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
   localparam int LINK = 20;
   localparam int MS = 4;
   logic sys_clk_in;
   logic rst_n_in;
   sflm_pkg::sflm_cause_t cause;
   logic alive;
   logic cmd;
   logic cmd_term;
   logic traffic;
   logic remote_req;
   logic start_active;
   logic start_done;
   logic [sflm_pkg::START_TIME_W-1:0] max_start;
   logic auto_clr;
   logic man_clr;
   logic [8:0] status;
   sflm_pkg::sflm_code_t code;
   logic any_f;
   sflm_pkg::sflm_hmi_t hmi;
   int err_total;
   int num_checks;

   sflm_partner #(.GAP(4)) partner_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .alive_in(alive), .cmd_in(cmd), .cmd_from_terminal_out(cmd_term),
      .link_traffic_out(traffic));

   sflm_fault_manager #(.LINK_SILENCE_CYCLES(LINK), .MS_TICK_CYCLES(MS)) dut_u (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cause_in(cause),
      .cmd_from_terminal_in(cmd_term), .link_traffic_in(traffic),
      .remote_hmi_request_in(remote_req), .start_active_in(start_active),
      .start_done_in(start_done), .max_start_time_in(max_start),
      .automatic_clear_in(auto_clr), .manual_clear_in(man_clr),
      .fault_status_out(status), .active_fault_out(code), .any_fault_out(any_f),
      .active_hmi_out(hmi));

   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic pulse_manual();
      man_clr = 1'b1;
      step(1);
      man_clr = 1'b0;
      step(2);
   endtask

   task automatic t_reset();
      rst_n_in = 1'b0;
      step(6);
      check("status", status, 9'h000);
      check("code", {5'h00, code}, 9'h000);
      check("hmi", {8'h00, hmi}, 9'h000);
      rst_n_in = 1'b1;
      step(1);
      check("any", {8'h00, any_f}, 9'h000);
   endtask

   task automatic t_security();
      logic [10:0] cz [4] = '{11'h001, 11'h002, 11'h004, 11'h008};
      int bz [4] = '{1, 1, 2, 2};
      for (int i = 0; i < 4; i++) begin
         cause = cz[i];
         step(3);
         check("status", status, 9'h001 << bz[i]);
         cause = 11'h000;
         step(3);
         check("status", status, 9'h000);
      end
   endtask

   task automatic t_clear_table();
      logic [10:0] cz [7] = '{11'h010, 11'h020, 11'h040, 11'h100, 11'h200, 11'h400, 11'h080};
      int bz [7] = '{3, 3, 4, 7, 8, 8, 5};
      for (int i = 0; i < 7; i++) begin
         cause = cz[i];
         step(3);
         check("status", status, 9'h001 << bz[i]);
         check("code", {5'h00, code}, 9'(bz[i] + 1));
         check("any", {8'h00, any_f}, 9'h001);
         auto_clr = (i >= 3);
         pulse_manual();
         check("status", status, 9'h001 << bz[i]);
         cause = 11'h000;
         step(3);
         check("status", status, (i >= 3 && bz[i] != 5) ? 9'h000 : 9'h001 << bz[i]);
         auto_clr = 1'b0;
         pulse_manual();
         check("status", status, 9'h000);
      end
   endtask

   task automatic t_link();
      cmd = 1'b1;
      step(15);
      check("status", status, 9'h000);
      step(15);
      check("status", status, 9'h001);
      check("hmi", {8'h00, hmi}, 9'h001);
      auto_clr = 1'b1;
      step(3);
      check("status", status, 9'h001);
      alive = 1'b1;
      step(6);
      check("status", status, 9'h000);
      check("hmi", {8'h00, hmi}, 9'h001);
      remote_req = 1'b1;
      step(1);
      remote_req = 1'b0;
      step(2);
      check("hmi", {8'h00, hmi}, 9'h000);
      cmd = 1'b0;
      alive = 1'b0;
      step(40);
      check("status", status, 9'h000);
      auto_clr = 1'b0;
   endtask

   task automatic t_long_start();
      max_start = 16'h0003;
      start_active = 1'b1;
      start_done = 1'b1;
      step(40);
      check("status", status, 9'h000);
      start_done = 1'b0;
      step(8);
      check("status", status, 9'h000);
      step(24);
      check("status", status, 9'h040);
      check("code", {5'h00, code}, 9'h007);
      start_active = 1'b0;
      auto_clr = 1'b1;
      step(3);
      check("status", status, 9'h040);
      pulse_manual();
      check("status", status, 9'h000);
      auto_clr = 1'b0;
   endtask

   task automatic t_priority();
      cause = 11'h240;
      step(3);
      check("status", status, 9'h110);
      check("code", {5'h00, code}, 9'h005);
      cause = 11'h000;
      step(2);
      t_reset();
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      err_total = 0;
      num_checks = 0;
      rst_n_in = 1'b0;
      cause = 11'h000;
      alive = 1'b0;
      cmd = 1'b0;
      remote_req = 1'b0;
      start_active = 1'b0;
      start_done = 1'b0;
      max_start = 16'h0000;
      auto_clr = 1'b0;
      man_clr = 1'b0;
      t_reset();
      t_security();
      t_clear_table();
      t_link();
      t_long_start();
      t_priority();
      end_sim();
   end

   // Whole run is under a thousand cycles
   initial begin
      #80000;
      err_total++;
      end_sim();
   end
endmodule
